// File: hw/obcd_pkg.sv
// Constants for the configuration byte store and decoder
package obcd_pkg;

	// ------------------------------------------------------------
	// Byte selection and stored values
	// ------------------------------------------------------------
	localparam logic       SEL_BYTE_LOW   = 1'b0;
	localparam logic       SEL_BYTE_HIGH  = 1'b1;
	localparam logic [7:0] ERASED_BYTE    = 8'h0_0FF;
	localparam logic [7:0] LOW_RESET_VAL  = 8'h0_0FC;
	localparam logic [7:0] HIGH_RESET_VAL = 8'h0_0EF;

	// ------------------------------------------------------------
	// Low byte field positions
	// ------------------------------------------------------------
	localparam int WAKE_CLK_BIT  = 7;
	localparam int RANGE_MSB     = 6;
	localparam int RANGE_LSB     = 4;
	localparam int SECTOR_MSB    = 3;
	localparam int SECTOR_LSB    = 2;
	localparam int READOUT_BIT   = 1;
	localparam int WRPROT_BIT    = 0;

	// ------------------------------------------------------------
	// High byte field positions
	// ------------------------------------------------------------
	localparam int PLL_FACTOR_BIT = 7;
	localparam int PLL_BYPASS_BIT = 6;
	localparam int RESERVED_BIT   = 5;
	localparam int RC_SELECT_BIT  = 4;
	localparam int VDET_MSB       = 3;
	localparam int VDET_LSB       = 2;
	localparam int WDG_START_BIT  = 1;
	localparam int WATCHDOG_HALT_RESET_BIT   = 0;

	// ------------------------------------------------------------
	// Oscillator range codes
	// ------------------------------------------------------------
	localparam logic [2:0] RANGE_LOW         = 3'h0;
	localparam logic [2:0] RANGE_MEDIUM      = 3'h1;
	localparam logic [2:0] RANGE_MEDIUM_HIGH = 3'h2;
	localparam logic [2:0] RANGE_HIGH        = 3'h3;
	localparam logic [2:0] RANGE_VLP_XTAL    = 3'h4;
	localparam logic [2:0] RANGE_EXT_A       = 3'h5;
	localparam logic [2:0] RANGE_RESERVED    = 3'h6;
	localparam logic [2:0] RANGE_EXT_B       = 3'h7;

	// ------------------------------------------------------------
	// Decoded values and synchroniser depth
	// ------------------------------------------------------------
	localparam logic [12:0] SECTOR_BASE_BYTES = 13'h0_200;
	localparam logic [3:0]  PLL_MULT_LOW      = 4'h4;
	localparam logic [3:0]  PLL_MULT_HIGH     = 4'h8;
	localparam logic [1:0]  VDET_OFF_CODE     = 2'h3;
	localparam int          SYNC_STAGES       = 2;

endpackage

// File: hw/obcd_store_if.sv
// Link between the decoder and the configuration byte store
`timescale 1ns/1ps
interface obcd_store_if;
	logic       wr;
	logic       erase;
	logic       sel;
	logic [7:0] wdata;
	logic [7:0] byte_low;
	logic [7:0] byte_high;

	modport ctrl  (output wr, erase, sel, wdata, input byte_low, byte_high);
	modport store (input wr, erase, sel, wdata, output byte_low, byte_high);
endinterface

// File: hw/obcd_store.sv
// Non-volatile configuration byte store
`timescale 1ns/1ps
module obcd_store (
	input  wire logic    i_clk,        // System clock
	input  wire logic    i_por_arst_n, // Power-on reset, low active
	obcd_store_if.store  bus           // Access from the decoder
);
	logic [7:0] mem [2];

	assign bus.byte_low  = mem[0];
	assign bus.byte_high = mem[1];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Of the two resets only power-on reloads it, so contents outlive the system reset
	always_ff @(posedge i_clk or negedge i_por_arst_n) begin
		if (!i_por_arst_n) begin
			mem[0] <= obcd_pkg::LOW_RESET_VAL;
			mem[1] <= obcd_pkg::HIGH_RESET_VAL;
		end else if (bus.erase) begin
			mem[0] <= obcd_pkg::ERASED_BYTE;
			mem[1] <= obcd_pkg::ERASED_BYTE;
		end else if (bus.wr) begin
			mem[bus.sel] <= bus.wdata;
		end
	end
endmodule

// File: hw/obcd_top.sv
// Configuration byte decoder with programming access and protection
`timescale 1ns/1ps

module obcd_top #(
	parameter int SYNC_STAGES = obcd_pkg::SYNC_STAGES
) (
	input  wire logic        i_clk,             // System clock
	input  wire logic        i_arst_n,          // System reset, low active
	input  wire logic        i_por_arst_n,      // Power-on reset, low active
	input  wire logic        i_prog_mode,       // Programming mode pin
	input  wire logic        i_prog_rd,         // Option byte read strobe
	input  wire logic        i_prog_wr,         // Option byte write strobe
	input  wire logic        i_prog_erase,      // Option erase strobe
	input  wire logic        i_prog_sel,        // 0 low byte, 1 high byte
	input  wire logic [7:0]  i_prog_wdata,      // Write data
	input  wire logic        i_mem_erase_done,  // Memory erase finished
	output logic [7:0]       o_prog_rdata,      // Read data
	output logic             o_prog_refused,    // Access refused pulse
	output logic             o_mem_erase_req,   // Whole memory erase request
	output logic             o_mem_read_block,  // Block memory extraction
	output logic             o_mem_write_block, // Block memory writes
	output logic             o_cfg_valid,       // Settings loaded
	output logic             o_wake_clk_rc,     // Wake timer uses RC osc
	output logic [2:0]       o_wake_range,      // Range used by wake clock
	output logic             o_rc_osc_en,       // Internal RC selected
	output logic [2:0]       o_osc_range,       // Main oscillator range
	output logic             o_osc_ext_clk,     // External clock input
	output logic             o_osc_range_bad,   // Reserved range code
	output logic [12:0]      o_sector_bytes,    // First sector size
	output logic [3:0]       o_pll_mult,        // PLL factor
	output logic             o_pll_bypass,      // PLL off and bypassed
	output logic             o_vdet_en,         // Voltage detectors on
	output logic [1:0]       o_vdet_level,      // 0 lowest, 2 highest
	output logic             o_wdg_hw_en,       // Watchdog on in hardware
	output logic             o_halt_reset_en    // Reset on halt entry
);
	typedef enum logic [1:0] {ST_IDLE, ST_MEM_ERASE, ST_OPT_ERASE}
		obcd_state_t;

	// Fewer than two stages would leave the mode pin metastable
	if (SYNC_STAGES < 2) begin : g_sync_check
		$error("SYNC_STAGES below two gives no safe crossing");
	end

	obcd_store_if sbus ();

	obcd_store u_store (
		.i_clk        (i_clk),
		.i_por_arst_n (i_por_arst_n),
		.bus          (sbus.store)
	);

	logic [SYNC_STAGES-1:0] mode_sync_r;
	logic                   mode_s;
	logic [7:0]             low_r;
	logic [7:0]             high_r;
	logic                   loaded_r;
	obcd_state_t            state_r;
	logic                   live_rdp;
	logic                   live_wp;
	logic                   acc_ok;
	logic                   wr_ok;
	logic                   erase_ok;
	logic [7:0]             wr_byte;
	logic                   wake_rc;
	logic [1:0]             sec_code;

	// ------------------------------------------------------------
	// Mode pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			mode_sync_r <= '0;
		else
			mode_sync_r <= {mode_sync_r[SYNC_STAGES-2:0], i_prog_mode};
	end
	assign mode_s = mode_sync_r[SYNC_STAGES-1];

	// ------------------------------------------------------------
	// Programming access
	// ------------------------------------------------------------
	assign live_rdp = sbus.byte_low[obcd_pkg::READOUT_BIT];
	assign live_wp  = sbus.byte_low[obcd_pkg::WRPROT_BIT];
	assign acc_ok   = mode_s && (state_r == ST_IDLE);
	assign wr_ok    = acc_ok && i_prog_wr;
	assign erase_ok = acc_ok && i_prog_erase && !i_prog_wr && !live_wp;

	always_comb begin
		wr_byte = i_prog_wdata;
		if (!i_prog_sel && live_wp)
			wr_byte[obcd_pkg::WRPROT_BIT] = 1'b1;
	end

	assign sbus.wr    = wr_ok;
	assign sbus.sel   = i_prog_sel;
	assign sbus.wdata = wr_byte;
	assign sbus.erase = (state_r == ST_OPT_ERASE);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_prog_rdata <= 8'h0_000;
		else if (acc_ok && i_prog_rd)
			o_prog_rdata <= i_prog_sel ? sbus.byte_high : sbus.byte_low;
		else
			o_prog_rdata <= 8'h0_000;
	end

	// Any strobe outside programming mode or during an erase is dropped
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_prog_refused <= 1'b0;
		else
			o_prog_refused <= (i_prog_rd || i_prog_wr || i_prog_erase)
				&& !(acc_ok && (i_prog_rd || i_prog_wr || erase_ok));
	end

	// ------------------------------------------------------------
	// Option erase sequence
	// ------------------------------------------------------------
	// memory erase first when read-out protection is set
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			state_r <= ST_IDLE;
		else
			case (state_r)
				ST_IDLE: begin
					if (erase_ok)
						state_r <= live_rdp ? ST_MEM_ERASE : ST_OPT_ERASE;
				end
				ST_MEM_ERASE: begin
					if (i_mem_erase_done)
						state_r <= ST_OPT_ERASE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_mem_erase_req <= 1'b0;
		else if (state_r == ST_IDLE)
			o_mem_erase_req <= erase_ok && live_rdp;
		else if (i_mem_erase_done)
			o_mem_erase_req <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_read_block  <= 1'b1;
			o_mem_write_block <= 1'b1;
		end else begin
			o_mem_read_block  <= live_rdp || low_r[obcd_pkg::READOUT_BIT];
			o_mem_write_block <= live_rdp || live_wp
				|| low_r[obcd_pkg::READOUT_BIT]
				|| low_r[obcd_pkg::WRPROT_BIT];
		end
	end

	// ------------------------------------------------------------
	// Holding registers
	// ------------------------------------------------------------
	// captured once after reset
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			low_r    <= obcd_pkg::LOW_RESET_VAL;
			high_r   <= obcd_pkg::HIGH_RESET_VAL;
			loaded_r <= 1'b0;
		end else if (!loaded_r) begin
			low_r    <= sbus.byte_low;
			high_r   <= sbus.byte_high;
			loaded_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Decoded settings
	// ------------------------------------------------------------
	assign wake_rc  = low_r[obcd_pkg::WAKE_CLK_BIT];
	assign sec_code = low_r[obcd_pkg::SECTOR_MSB:obcd_pkg::SECTOR_LSB];

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cfg_valid    <= 1'b0;
			o_wake_clk_rc  <= 1'b1;
			o_wake_range   <= obcd_pkg::RANGE_VLP_XTAL;
			o_sector_bytes <= obcd_pkg::SECTOR_BASE_BYTES;
		end else begin
			o_cfg_valid    <= loaded_r;
			o_wake_clk_rc  <= wake_rc;
			o_wake_range   <= wake_rc
				? low_r[obcd_pkg::RANGE_MSB:obcd_pkg::RANGE_LSB]
				: obcd_pkg::RANGE_VLP_XTAL;
			o_sector_bytes <= obcd_pkg::SECTOR_BASE_BYTES << sec_code;
		end
	end

	// Range only matters while the internal RC is off
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rc_osc_en     <= 1'b1;
			o_osc_range     <= obcd_pkg::RANGE_LOW;
			o_osc_ext_clk   <= 1'b0;
			o_osc_range_bad <= 1'b0;
		end else begin
			o_rc_osc_en <= !high_r[obcd_pkg::RC_SELECT_BIT];
			o_osc_range <= low_r[obcd_pkg::RANGE_MSB:obcd_pkg::RANGE_LSB];
			o_osc_ext_clk <= high_r[obcd_pkg::RC_SELECT_BIT] &&
				(low_r[obcd_pkg::RANGE_MSB:obcd_pkg::RANGE_LSB]
					== obcd_pkg::RANGE_EXT_A ||
				 low_r[obcd_pkg::RANGE_MSB:obcd_pkg::RANGE_LSB]
					== obcd_pkg::RANGE_EXT_B);
			o_osc_range_bad <= high_r[obcd_pkg::RC_SELECT_BIT] &&
				(low_r[obcd_pkg::RANGE_MSB:obcd_pkg::RANGE_LSB]
					== obcd_pkg::RANGE_RESERVED);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pll_mult      <= obcd_pkg::PLL_MULT_HIGH;
			o_pll_bypass    <= 1'b1;
			o_vdet_en       <= 1'b0;
			o_vdet_level    <= 2'h0;
			o_wdg_hw_en     <= 1'b0;
			o_halt_reset_en <= 1'b1;
		end else begin
			o_pll_mult <= high_r[obcd_pkg::PLL_FACTOR_BIT]
				? obcd_pkg::PLL_MULT_HIGH : obcd_pkg::PLL_MULT_LOW;
			o_pll_bypass <= high_r[obcd_pkg::PLL_BYPASS_BIT];
			o_vdet_en <= high_r[obcd_pkg::VDET_MSB:obcd_pkg::VDET_LSB]
				!= obcd_pkg::VDET_OFF_CODE;
			o_vdet_level <= high_r[obcd_pkg::VDET_MSB:obcd_pkg::VDET_LSB];
			o_wdg_hw_en <= !high_r[obcd_pkg::WDG_START_BIT];
			o_halt_reset_en <= high_r[obcd_pkg::WATCHDOG_HALT_RESET_BIT];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	a_wake_src_map: assert property (
		o_cfg_valid |-> o_wake_clk_rc == $past(wake_rc))
		else $error("wake clock source differs from stored bit");
	a_wake_range_forced: assert property (
		o_cfg_valid && !o_wake_clk_rc |->
			o_wake_range == obcd_pkg::RANGE_VLP_XTAL)
		else $error("wake range not forced low-power");
	a_ext_clk_rc_off: assert property (
		o_osc_ext_clk |-> !o_rc_osc_en && o_osc_range[2] && o_osc_range[0])
		else $error("external clock flagged with wrong range");
	a_sector_size: assert property (
		o_cfg_valid |-> o_sector_bytes ==
			(13'h0_200 << $past(sec_code)))
		else $error("sector size decode wrong");
	a_rdp_blocks: assert property (
		live_rdp |=> o_mem_read_block && o_mem_write_block)
		else $error("read-out protection not blocking memory");
	a_erase_order: assert property (
		state_r == ST_IDLE && erase_ok && live_rdp |=>
			o_mem_erase_req && !sbus.erase)
		else $error("options erased before memory");
	a_wp_no_erase: assert property (
		live_wp |-> !sbus.erase ##1 live_wp)
		else $error("write protection bit changed");
	a_mode_gate: assert property (
		!mode_s |-> !sbus.wr ##1 o_prog_rdata == 8'h0_000)
		else $error("access outside programming mode");
	a_pll_factor: assert property (
		o_cfg_valid |-> o_pll_mult == ($past(high_r[7]) ? 4'h8 : 4'h4))
		else $error("PLL factor decode wrong");
	a_vdet_off: assert property (
		o_cfg_valid |-> o_vdet_en == (o_vdet_level != 2'h3))
		else $error("voltage detector enable wrong");
	a_settings_stable: assert property (
		o_cfg_valid |=> $stable(o_wdg_hw_en) && $stable(o_halt_reset_en)
			&& $stable(o_pll_bypass) && $stable(o_rc_osc_en))
		else $error("settings changed during operation");

	c_opt_write: cover property (mode_s && sbus.wr);
	c_rdp_erase: cover property (o_mem_erase_req ##[1:20] sbus.erase);
	c_refused:   cover property (o_prog_refused);
endmodule

// File: sim/obcd_prog_tool.sv
// Programming tool and program memory stand-in for the decoder bench
`timescale 1ns/1ps
module obcd_prog_tool #(
	parameter int ERASE_DLY = 8
) (
	input  wire logic       i_clk,           // System clock
	input  wire logic       i_mem_erase_req, // Memory erase request
	output logic            o_prog_mode,     // Programming mode pin
	output logic            o_rd,            // Read strobe
	output logic            o_wr,            // Write strobe
	output logic            o_erase,         // Option erase strobe
	output logic            o_sel,           // Byte select
	output logic [7:0]      o_wdata,         // Write data
	output logic            o_mem_erase_done // Memory erase finished
);
	int cnt;

	initial begin
		o_prog_mode = 1'b0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_erase = 1'b0;
		o_sel = 1'b0;
		o_wdata = 8'h5A;
		o_mem_erase_done = 1'b0;
		cnt = 0;
	end

	task automatic set_mode(input logic m);
		@(posedge i_clk);
		#1;
		o_prog_mode = m;
	endtask

	// One strobe per call, held across exactly one sampling edge
	task automatic access(input logic rd, wr, er, sel, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_rd = rd;
		o_wr = wr;
		o_erase = er;
		o_sel = sel;
		o_wdata = sel ? (d | 8'h20) : d;
		@(posedge i_clk);
		#1;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_erase = 1'b0;
		// Released lines must not keep a stale value
		o_sel = ~o_sel;
		o_wdata = ~o_wdata;
	endtask

	// Slow memory erase, one-cycle done pulse
	always @(posedge i_clk) begin
		#1;
		if (i_mem_erase_req && !o_mem_erase_done) begin
			cnt = cnt + 1;
			if (cnt == ERASE_DLY) begin
				o_mem_erase_done = 1'b1;
				cnt = 0;
			end
		end else begin
			o_mem_erase_done = 1'b0;
		end
	end
endmodule

// File: sim/test_option_byte_config_decoder.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/1ps
module test_option_byte_config_decoder;
	logic        i_clk;
	logic        i_arst_n;
	logic        i_por_arst_n;
	wire         mode, rd, wr, er, sel, done;
	wire  [7:0]  wdata;
	wire  [7:0]  rdata;
	wire         refused, erase_req, cfg_valid;
	wire  [34:0] cfg_got;
	int          n_fail;
	int          samples_checked;

	obcd_top dut (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_por_arst_n(i_por_arst_n),
		.i_prog_mode(mode), .i_prog_rd(rd), .i_prog_wr(wr),
		.i_prog_erase(er), .i_prog_sel(sel), .i_prog_wdata(wdata),
		.i_mem_erase_done(done), .o_prog_rdata(rdata),
		.o_prog_refused(refused), .o_mem_erase_req(erase_req),
		.o_mem_read_block(cfg_got[34]), .o_mem_write_block(cfg_got[33]),
		.o_cfg_valid(cfg_valid), .o_wake_clk_rc(cfg_got[32]),
		.o_wake_range(cfg_got[31:29]), .o_rc_osc_en(cfg_got[28]),
		.o_osc_range(cfg_got[27:25]), .o_osc_ext_clk(cfg_got[24]),
		.o_osc_range_bad(cfg_got[23]), .o_sector_bytes(cfg_got[22:10]),
		.o_pll_mult(cfg_got[9:6]), .o_pll_bypass(cfg_got[5]),
		.o_vdet_en(cfg_got[4]), .o_vdet_level(cfg_got[3:2]),
		.o_wdg_hw_en(cfg_got[1]), .o_halt_reset_en(cfg_got[0])
	);

	obcd_prog_tool tool (
		.i_clk(i_clk), .i_mem_erase_req(erase_req), .o_prog_mode(mode),
		.o_rd(rd), .o_wr(wr), .o_erase(er), .o_sel(sel), .o_wdata(wdata),
		.o_mem_erase_done(done)
	);

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Expected settings and compares
	// ------------------------------------------------------------
	function automatic logic [34:0] exp_cfg(input logic [7:0] lo, hi);
		logic [2:0] r;
		r = lo[6:4];
		return {lo[1], lo[1] | lo[0], lo[7], lo[7] ? r : 3'h4, ~hi[4], r,
			hi[4] & (r == 3'h5 || r == 3'h7), hi[4] & (r == 3'h6),
			13'h0200 << lo[3:2], hi[7] ? 4'h8 : 4'h4, hi[6],
			hi[3:2] != 2'h3, hi[3:2], ~hi[1], hi[0]};
	endfunction

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_cfg(input logic [34:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: settings %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s %b not %b", $time, m, got, exp);
		end
	endtask

	// Reload holding registers; request lines stay idle meanwhile
	task automatic sys_rst;
		@(posedge i_clk);
		#1;
		i_arst_n = 1'b0;
		@(posedge i_clk);
		#1;
		i_arst_n = 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		chk_bit(cfg_valid, 1'b1, "valid");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] lo, hi, plo, phi;
		int k;
		i_arst_n = 1'b0;
		i_por_arst_n = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		repeat (2) @(posedge i_clk);
		#1;
		chk_cfg(cfg_got, {2'h3, 1'b1, 3'h4, 1'b1, 3'h0, 2'h0, 13'h0200,
			4'h8, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1});
		chk_bit(cfg_valid, 1'b0, "valid in reset");
		repeat (4) @(posedge i_clk);
		#1;
		i_arst_n = 1'b1;
		i_por_arst_n = 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		plo = 8'hFC;
		phi = 8'hEF;
		chk_cfg(cfg_got, exp_cfg(plo, phi));
		// Outside programming mode everything is refused
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_byte(rdata, 8'h00, "read no mode");
		chk_bit(refused, 1'b1, "refused read");
		tool.access(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		chk_bit(refused, 1'b1, "refused write");
		tool.set_mode(1'b1);
		repeat (3) @(posedge i_clk);
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_byte(rdata, plo, "low byte");
		chk_bit(refused, 1'b0, "read taken");
		tool.access(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
		chk_byte(rdata, phi, "high byte");
		// Sweep all eight range codes; new settings show only after reset
		for (k = 0; k < 8; k++) begin
			lo = {k[2] | k[1], k[2:0], k[1:0], 2'h0};
			hi = {k[0], k[1], 1'b1, k[2], k[1:0], k[0], ~k[0]};
			tool.access(1'b0, 1'b1, 1'b0, 1'b0, lo);
			tool.access(1'b0, 1'b1, 1'b0, 1'b1, hi);
			chk_cfg(cfg_got, exp_cfg(plo, phi));
			tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
			chk_byte(rdata, lo, "written low");
			sys_rst();
			chk_cfg(cfg_got, exp_cfg(lo, hi));
			plo = lo;
			phi = hi;
		end
		// Read-out protection, then option erase via memory erase
		tool.access(1'b0, 1'b1, 1'b0, 1'b0, 8'hFE);
		@(posedge i_clk);
		#1;
		chk_bit(cfg_got[34], 1'b1, "read block");
		chk_bit(cfg_got[33], 1'b1, "write block");
		tool.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		chk_bit(erase_req, 1'b1, "memory erase");
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_bit(refused, 1'b1, "busy read");
		for (k = 0; k < 100 && erase_req === 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		if (k == 100) begin
			n_fail++;
			$display("wrong value at %0t: memory erase never ended", $time);
			test_done();
		end
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_byte(rdata, 8'hFF, "erased low");
		// Erased byte carries write protection: bit sticks, no erase
		tool.access(1'b0, 1'b1, 1'b0, 1'b0, 8'hFC);
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_byte(rdata, 8'hFD, "protect bit");
		tool.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		chk_bit(refused, 1'b1, "erase refused");
		tool.access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		chk_byte(rdata, 8'hFD, "kept low");
		chk_bit(cfg_got[34], 1'b0, "read open");
		chk_bit(cfg_got[33], 1'b1, "write shut");
		test_done();
	end
endmodule
